// file: src/uie_pkg.sv
// Purpose: constants and types for the uart interrupt enable logic
// Assumes: one channel per instance, 50 MHz ref_clk_i
// Notes: line status and modem status arrive from the channel core
//
// Behaviour
// - mask bit 7 set raises interrupt on clear-to-send rising edge.
// - mask bit 6 set raises interrupt on request-to-send rising edge.
// - mask bit 5 gates the stop-character interrupt; clear means none.
// - mask bit 4 drives sleep mode; resets to zero.
// - mask bit 3 raises modem interrupt when any modem change indicator sets.
// - mask bit 2 raises line interrupt while line status bits 4..1 present.
// - mask bit 1 raises transmit-empty at level 3; holding or fifo empty.
// - mask bit 0 raises receive-ready at level 2; data or trigger level.
// - each channel drives its own interrupt output pin.
// - receive status in source status follows trigger level with interrupt.
// - receive data ready sets on character into fifo, clears when empty.
// - transmit fifo emptied by shifter interrupts; clears on status read or write.
// - fifo on with all low four mask bits set (polled) gives no interrupts from those four sources.
// - line bit 5 transmit fifo empty, bit 6 fifo and shifter empty.
// - line bits 4..1 report receive errors or break for polling.
// - line bit 7 flags any data error held in receive fifo.
// - upper four mask bits writable only while enhanced bit 4 set.
`default_nettype none
package uie_pkg;
	localparam int MASK_W      = 8;
	localparam int B_CTS       = 7;
	localparam int B_RTS       = 6;
	localparam int B_XOFF      = 5;
	localparam int B_SLEEP     = 4;
	localparam int B_MODEM     = 3;
	localparam int B_LINE      = 2;
	localparam int B_TXE       = 1;
	localparam int B_RXR       = 0;
	localparam logic [7:0] MASK_RST  = 8'h00;
	localparam logic [7:0] UPPER_MSK = 8'hf0;
	localparam logic [7:0] LOWER_MSK = 8'h0f;
	localparam int LVL_W = 8;
	// source status priority codes (bits 5:0)
	localparam logic [5:0] SRC_NONE  = 6'h01;
	localparam logic [5:0] SRC_LINE  = 6'h06;
	localparam logic [5:0] SRC_RXR   = 6'h04;
	localparam logic [5:0] SRC_TXE   = 6'h02;
	localparam logic [5:0] SRC_MODEM = 6'h00;
	localparam logic [5:0] SRC_XOFF  = 6'h10;
	localparam logic [5:0] SRC_CTRTS = 6'h20;

	typedef struct packed {
		logic       fifo_en;     // fifo_control bit 0
		logic       rx_push;     // char moved from rx_shifter into fifo
		logic       rx_hold_full;
		logic [7:0] rx_level;
		logic [7:0] rx_trigger;
		logic       rx_err_in_fifo;
		logic [3:0] rx_err;       // break, framing, parity, overrun
		logic       tx_fifo_empty;
		logic       tx_shift_empty;
		logic       tx_shift_load; // shifter takes last byte
		logic [3:0] modem_delta;
		logic       xoff_seen;
	} uie_core_t;

	typedef struct packed {
		logic       wr;
		logic       rd_src;     // read of interrupt_source_status
		logic       wr_tx;      // write of tx_holding
		logic [7:0] wdata;
		logic       efr_en;     // enhanced_feature_control bit 4
	} uie_host_t;
endpackage : uie_pkg
`default_nettype wire

// file: src/uie_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: single bit levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module uie_sync (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// data
	input  wire logic d_i,
	output var  logic q_o
);
	logic meta_ff;
	logic nxt_meta;
	logic nxt_q;
	always_comb begin
		nxt_meta = d_i;
		nxt_q    = meta_ff;
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= 1'b0;
			q_o     <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			q_o     <= nxt_q;
		end
	end
endmodule // uie_sync
`default_nettype wire

// file: src/uie_top.sv
// Purpose: interrupt mask, source qualification and line status for one channel
// Assumes: host strobes are one-cycle pulses on ref_clk_i
// Notes: clear_to_send_in is an active-low pin, synchronised here
`timescale 1ns/1ps
`default_nettype none
module uie_top (
	// clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// host side
	input  wire uie_pkg::uie_host_t host_i,
	// channel core
	input  wire uie_pkg::uie_core_t core_i,
	input  wire logic              clear_to_send_in_n_i,
	input  wire logic              request_to_send_out_n_i,
	// outputs
	output var  logic [7:0]        interrupt_mask_o,
	output var  logic [7:0]        interrupt_source_status_o,
	output var  logic [7:0]        line_status_o,
	output var  logic              sleep_o,
	output var  logic              irq_out_o
);
	import uie_pkg::*;

	// ********************************
	// pin synchronisation
	// ********************************
	logic cts_n_s;
	uie_sync uie_sync_inst (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.d_i       (clear_to_send_in_n_i),
		.q_o       (cts_n_s)
	);

	// ********************************
	// mask register
	// ********************************
	logic [7:0] mask_ff;
	logic [7:0] nxt_mask;
	logic [7:0] wmask;
	always_comb begin
		wmask    = host_i.efr_en ? (UPPER_MSK | LOWER_MSK) : LOWER_MSK;
		nxt_mask = mask_ff;
		if (host_i.wr) begin
			nxt_mask = (host_i.wdata & wmask) | (mask_ff & ~wmask);
		end
	end

	// ********************************
	// pending sources
	// ********************************
	logic       cts_ff;
	logic       rts_ff;
	logic       cts_pend_ff;
	logic       rts_pend_ff;
	logic       modem_pend_ff;
	logic       xoff_pend_ff;
	logic       txe_pend_ff;
	logic       nxt_cts;
	logic       nxt_rts;
	logic       nxt_cts_pend;
	logic       nxt_rts_pend;
	logic       nxt_modem_pend;
	logic       nxt_xoff_pend;
	logic       nxt_txe_pend;
	logic       polled;
	logic       rx_ready;
	logic       line_pend;
	logic       txe_cond;
	logic [7:0] act;
	logic [5:0] src;

	always_comb begin
		// pin levels, active low so rising pin edge is 0->1 of the pin itself
		nxt_cts = cts_n_s;
		nxt_rts = request_to_send_out_n_i;
		polled  = core_i.fifo_en & (mask_ff[3:0] == LOWER_MSK[3:0]);
		// level sources
		if (core_i.fifo_en) begin
			rx_ready = (core_i.rx_level >= core_i.rx_trigger) && (|core_i.rx_level);
			txe_cond = txe_pend_ff;
		end else begin
			rx_ready = core_i.rx_hold_full;
			txe_cond = core_i.tx_fifo_empty;
		end
		line_pend = |core_i.rx_err;
		// sticky sources except modem (which follows modem_delta): set wins over clear
		nxt_cts_pend = cts_pend_ff;
		if (host_i.rd_src) nxt_cts_pend = 1'b0;
		if (~cts_ff & cts_n_s) nxt_cts_pend = 1'b1;
		nxt_rts_pend = rts_pend_ff;
		if (host_i.rd_src) nxt_rts_pend = 1'b0;
		if (~rts_ff & request_to_send_out_n_i) nxt_rts_pend = 1'b1;
		nxt_modem_pend = |core_i.modem_delta;
		nxt_xoff_pend = xoff_pend_ff;
		if (host_i.rd_src) nxt_xoff_pend = 1'b0;
		if (core_i.xoff_seen) nxt_xoff_pend = 1'b1;
		nxt_txe_pend = txe_pend_ff;
		if (host_i.rd_src | host_i.wr_tx) nxt_txe_pend = 1'b0;
		if (core_i.tx_shift_load & core_i.tx_fifo_empty) nxt_txe_pend = 1'b1;
		// masked sources
		act[B_CTS]   = mask_ff[B_CTS] & cts_pend_ff;
		act[B_RTS]   = mask_ff[B_RTS] & rts_pend_ff;
		act[B_XOFF]  = mask_ff[B_XOFF] & xoff_pend_ff;
		act[B_SLEEP] = 1'b0;
		act[B_MODEM] = mask_ff[B_MODEM] & modem_pend_ff & ~polled;
		act[B_LINE]  = mask_ff[B_LINE] & line_pend & ~polled;
		act[B_TXE]   = mask_ff[B_TXE] & txe_cond & ~polled;
		act[B_RXR]   = mask_ff[B_RXR] & rx_ready & ~polled;
		// priority encode
		if (act[B_LINE])                src = SRC_LINE;
		else if (act[B_RXR])            src = SRC_RXR;
		else if (act[B_TXE])            src = SRC_TXE;
		else if (act[B_MODEM])          src = SRC_MODEM;
		else if (act[B_XOFF])           src = SRC_XOFF;
		else if (act[B_CTS] | act[B_RTS]) src = SRC_CTRTS;
		else                            src = SRC_NONE;
	end

	// ********************************
	// line status
	// ********************************
	logic [7:0] nxt_line;
	logic       rdr_ff;
	logic       nxt_rdr;
	always_comb begin
		nxt_rdr = rdr_ff;
		if (!(|core_i.rx_level) && !core_i.rx_push) nxt_rdr = 1'b0;
		if (core_i.rx_push) nxt_rdr = 1'b1;
		nxt_line[0]   = nxt_rdr;
		nxt_line[4:1] = core_i.rx_err;
		nxt_line[5]   = core_i.tx_fifo_empty;
		nxt_line[6]   = core_i.tx_fifo_empty & core_i.tx_shift_empty;
		nxt_line[7]   = core_i.fifo_en & core_i.rx_err_in_fifo;
	end

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_ff          <= MASK_RST;
			interrupt_mask_o <= MASK_RST;
			sleep_o          <= 1'b0;
		end else begin
			mask_ff          <= nxt_mask;
			interrupt_mask_o <= nxt_mask;
			sleep_o          <= nxt_mask[B_SLEEP];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cts_ff        <= 1'b0;
			rts_ff        <= 1'b0;
			cts_pend_ff   <= 1'b0;
			rts_pend_ff   <= 1'b0;
			modem_pend_ff <= 1'b0;
			xoff_pend_ff  <= 1'b0;
			txe_pend_ff   <= 1'b0;
		end else begin
			cts_ff        <= nxt_cts;
			rts_ff        <= nxt_rts;
			cts_pend_ff   <= nxt_cts_pend;
			rts_pend_ff   <= nxt_rts_pend;
			modem_pend_ff <= nxt_modem_pend;
			xoff_pend_ff  <= nxt_xoff_pend;
			txe_pend_ff   <= nxt_txe_pend;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdr_ff        <= 1'b0;
			line_status_o <= '0;
		end else begin
			rdr_ff        <= nxt_rdr;
			line_status_o <= nxt_line;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			interrupt_source_status_o <= {2'b00, SRC_NONE};
			irq_out_o                 <= 1'b0;
		end else begin
			interrupt_source_status_o <= {2'b00, src};
			irq_out_o                 <= |act;
		end
	end

	// ********************************
	// checks: mask and output
	// ********************************
	upper_lock_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(host_i.wr && !host_i.efr_en) |=> (mask_ff[7:4] == $past(mask_ff[7:4])))
		else $error("upper mask bits changed while locked");
	lower_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		host_i.wr |=> ((mask_ff & LOWER_MSK) == ($past(host_i.wdata) & LOWER_MSK)))
		else $error("lower mask bits not written");
	sleep_follow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		##1 sleep_o == mask_ff[B_SLEEP])
		else $error("sleep output disagrees with mask");
	sleep_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(host_i.wr && host_i.efr_en && host_i.wdata[B_SLEEP]) |=> sleep_o)
		else $error("sleep not entered on write");
	irq_track_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		|act |=> irq_out_o)
		else $error("irq not raised for pending source");
	irq_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(|act) |=> !irq_out_o)
		else $error("irq raised with nothing pending");
	polled_quiet_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		polled |-> !(act[B_RXR] | act[B_TXE] | act[B_LINE] | act[B_MODEM]))
		else $error("interrupt in polled mode");

	// ********************************
	// checks: edge and sticky sources
	// ********************************
	cts_edge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!cts_ff && cts_n_s) |=> cts_pend_ff)
		else $error("clear-to-send edge lost");
	cts_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(mask_ff[B_CTS] && cts_pend_ff) |=> irq_out_o)
		else $error("clear-to-send interrupt missing");
	rts_edge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!rts_ff && request_to_send_out_n_i) |=> rts_pend_ff)
		else $error("request-to-send edge lost");
	rts_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(mask_ff[B_RTS] && rts_pend_ff) |=> irq_out_o)
		else $error("request-to-send interrupt missing");
	xoff_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		core_i.xoff_seen |=> xoff_pend_ff)
		else $error("stop character not held pending");
	xoff_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!mask_ff[B_XOFF] |-> !act[B_XOFF])
		else $error("stop character interrupt not gated");
	txe_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(core_i.tx_shift_load && core_i.tx_fifo_empty) |=> txe_pend_ff)
		else $error("transmit empty not set on fifo drain");
	txe_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(host_i.wr_tx && !(core_i.tx_shift_load && core_i.tx_fifo_empty)) |=> !txe_pend_ff)
		else $error("transmit empty not cleared by write");
	txe_rd_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(host_i.rd_src && !(core_i.tx_shift_load && core_i.tx_fifo_empty)) |=> !txe_pend_ff)
		else $error("transmit empty not cleared by status read");

	// ********************************
	// checks: level sources and line status
	// ********************************
	modem_pend_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(|core_i.modem_delta) |=> modem_pend_ff)
		else $error("modem change not pending");
	modem_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(mask_ff[B_MODEM] && modem_pend_ff && !polled) |=> irq_out_o)
		else $error("modem interrupt missing");
	line_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(mask_ff[B_LINE] && (|core_i.rx_err) && !polled) |=> irq_out_o)
		else $error("line interrupt missing");
	line_src_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(mask_ff[B_LINE] && (|core_i.rx_err) && !polled) |=> (interrupt_source_status_o[5:0] == SRC_LINE))
		else $error("line source code missing");
	txe_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(mask_ff[B_TXE] && !core_i.fifo_en && core_i.tx_fifo_empty) |=> irq_out_o)
		else $error("transmit empty interrupt missing");
	rxr_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(mask_ff[B_RXR] && !core_i.fifo_en && core_i.rx_hold_full) |=> irq_out_o)
		else $error("receive ready interrupt missing");
	rx_trig_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(mask_ff[B_RXR] && core_i.fifo_en && !polled && (|core_i.rx_level)
		&& (core_i.rx_level >= core_i.rx_trigger)) |=> irq_out_o)
		else $error("trigger level interrupt missing");
	rx_below_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(core_i.fifo_en && (core_i.rx_level < core_i.rx_trigger)) |-> !act[B_RXR])
		else $error("receive ready below trigger level");
	src_rx_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(act[B_RXR] && !act[B_LINE]) |=> (interrupt_source_status_o[5:0] == SRC_RXR))
		else $error("receive source code missing");
	rdr_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		core_i.rx_push |=> line_status_o[0])
		else $error("data ready not set on push");
	rdr_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!core_i.rx_push && (|core_i.rx_level)) |=> (rdr_ff == $past(rdr_ff)))
		else $error("data ready changed while fifo holds data");
	lsr_temt_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		##1 line_status_o[6] |-> line_status_o[5])
		else $error("shifter-empty without fifo-empty");
	lsr_thre_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		core_i.tx_fifo_empty |=> line_status_o[5])
		else $error("fifo empty not reported");
	lsr_full_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!core_i.tx_fifo_empty |=> !line_status_o[5])
		else $error("fifo empty reported while data held");
	lsr_err_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		1'b1 |=> (line_status_o[4:1] == $past(core_i.rx_err)))
		else $error("receive error bits not reported");
	lsr_ferr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(core_i.fifo_en && core_i.rx_err_in_fifo) |=> line_status_o[7])
		else $error("fifo data error not reported");
	lsr_fok_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!core_i.rx_err_in_fifo |=> !line_status_o[7])
		else $error("fifo data error reported without cause");
endmodule // uie_top
`default_nettype wire

// file: testbench/uie_host_model.sv
// Purpose: host cpu model driving the mask write and status strobes
// Assumes: strobes are one-cycle pulses launched just after a rising edge
// Notes: data lines are scrambled once a write is over
`timescale 1ns/1ps
`default_nettype none
module uie_host_model (
	// clock
	input  wire logic               ref_clk_i,
	// host strobes
	output var  uie_pkg::uie_host_t host_o
);
	import uie_pkg::*;
	initial host_o = '0;
	// ***************************************
	// bus cycles
	// ***************************************
	task automatic wr_mask(input logic [7:0] d, input logic e);
		@(posedge ref_clk_i);
		host_o.efr_en <= e;
		@(posedge ref_clk_i);
		host_o.wdata <= d;
		host_o.wr    <= 1'b1;
		@(posedge ref_clk_i);
		host_o.wr    <= 1'b0;
		host_o.wdata <= ~d;
	endtask
	task automatic strobe(input logic rd, input logic tx);
		@(posedge ref_clk_i);
		host_o.rd_src <= rd;
		host_o.wr_tx  <= tx;
		@(posedge ref_clk_i);
		host_o.rd_src <= 1'b0;
		host_o.wr_tx  <= 1'b0;
	endtask
endmodule // uie_host_model
`default_nettype wire

// file: testbench/uie_top_tb.sv
// Purpose: self-checking bench for the interrupt mask block
// Assumes: levels settle within six cycles of their cause
// Notes: the driver queues notes, a watcher compares them
`timescale 1ns/1ps
`default_nettype none
module uie_top_tb;
	import uie_pkg::*;
	typedef struct {logic [5:0] s; logic [7:0] l; logic [7:0] lm; logic q; logic [7:0] m;} uie_note_t;
	localparam logic [5:0] CODES [4] = '{SRC_RXR, SRC_TXE, SRC_LINE, SRC_MODEM};
	logic      ref_clk_i, rst_i, cts_n, rts_n, look, sleep_o, irq_o;
	logic [7:0] mask_o, src_o, line_o, mk, lv;
	logic [31:0] r;
	uie_host_t host;
	uie_core_t core;
	int        n_mismatch, tests_run, seed;
	uie_note_t notes[$];
	uie_top uie_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_i(host), .core_i(core),
		.clear_to_send_in_n_i(cts_n), .request_to_send_out_n_i(rts_n), .interrupt_mask_o(mask_o),
		.interrupt_source_status_o(src_o), .line_status_o(line_o), .sleep_o(sleep_o), .irq_out_o(irq_o));
	uie_host_model uie_host_model_inst (.ref_clk_i(ref_clk_i), .host_o(host));
	// ***************************************
	// helpers
	// ***************************************
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic note(input logic [5:0] s, input logic q, input logic [7:0] l = 8'h00, input logic [7:0] lm = 8'h00);
		repeat (6) @(posedge ref_clk_i);
		notes.push_back('{s, l, lm, q, mk});
		look <= 1'b1;
		@(posedge ref_clk_i);
		look <= 1'b0;
	endtask
	task automatic wm(input logic [7:0] d, input logic e);
		uie_host_model_inst.wr_mask(d, e);
		mk = e ? d : {mk[7:4], d[3:0]};
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk_i) begin : watch
		uie_note_t n;
		if (look && notes.size() > 0) begin
			n = notes.pop_front();
			cmp("mask", n.m, mask_o);
			cmp("source", {2'b00, n.s}, src_o & 8'h3f);
			cmp("line", n.l & n.lm, line_o & n.lm);
			cmp("irq", {7'h00, n.q}, {7'h00, irq_o});
			cmp("sleep", {7'h00, n.m[4]}, {7'h00, sleep_o});
		end
	end
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (3000) @(posedge ref_clk_i);
		n_mismatch++;
		wrap_up();
	end
	// ***************************************
	// scenarios
	// ***************************************
	initial begin
		rst_i = 1'b1;
		cts_n = 1'b0;
		rts_n = 1'b0;
		look = 1'b0;
		core = '0;
		mk = 8'h00;
		n_mismatch = 0;
		tests_run = 0;
		seed = 32'h0b5da5bb;
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		note(SRC_NONE, 1'b0, 8'h00, 8'hff);
		wm(8'hf0, 1'b0);
		note(SRC_NONE, 1'b0);
		wm(8'h10, 1'b1);
		note(SRC_NONE, 1'b0);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			lv = (i == 2) ? {3'h0, r[3:0] | 4'h1, 1'b0} : 8'h00;
			@(posedge ref_clk_i);
			core.rx_hold_full  <= (i == 0);
			core.tx_fifo_empty <= (i == 1);
			core.rx_err        <= lv[4:1];
			core.modem_delta   <= (i == 3) ? (r[7:4] | 4'h1) : 4'h0;
			wm(8'h00, 1'b1);
			note(SRC_NONE, 1'b0, lv, 8'h1e);
			wm(8'h01 << i, 1'b1);
			note(CODES[i], 1'b1, lv, 8'h1e);
		end
		@(posedge ref_clk_i);
		core <= '{fifo_en: 1'b1, rx_trigger: 8'h04, rx_level: 8'h03, default: '0};
		wm(8'h01, 1'b1);
		@(posedge ref_clk_i);
		core.rx_push <= 1'b1;
		@(posedge ref_clk_i);
		core.rx_push <= 1'b0;
		note(SRC_NONE, 1'b0, 8'h01, 8'h01);
		@(posedge ref_clk_i);
		core.rx_level <= 8'h04;
		note(SRC_RXR, 1'b1);
		@(posedge ref_clk_i);
		core.rx_level <= 8'h03;
		note(SRC_NONE, 1'b0);
		@(posedge ref_clk_i);
		core.rx_level <= 8'h00;
		note(SRC_NONE, 1'b0, 8'h00, 8'h01);
		wm(8'h02, 1'b1);
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk_i);
			core.tx_fifo_empty <= 1'b1;
			core.tx_shift_load <= 1'b1;
			@(posedge ref_clk_i);
			core.tx_shift_load <= 1'b0;
			note(SRC_TXE, 1'b1, 8'h20, 8'h60);
			uie_host_model_inst.strobe(k == 0, k == 1);
			note(SRC_NONE, 1'b0);
		end
		@(posedge ref_clk_i);
		core.tx_shift_empty <= 1'b1;
		core.rx_err_in_fifo <= 1'b1;
		core.rx_err         <= 4'h5;
		wm(8'h0f, 1'b1);
		note(SRC_NONE, 1'b0, 8'hea, 8'hfe);
		@(posedge ref_clk_i);
		core <= '0;
		wm(8'hc0, 1'b1);
		@(posedge ref_clk_i);
		cts_n <= 1'b1;
		note(SRC_CTRTS, 1'b1);
		uie_host_model_inst.strobe(1'b1, 1'b0);
		note(SRC_NONE, 1'b0);
		@(posedge ref_clk_i);
		rts_n <= 1'b1;
		note(SRC_CTRTS, 1'b1);
		uie_host_model_inst.strobe(1'b1, 1'b0);
		for (int x = 0; x < 2; x++) begin
			wm(x == 0 ? 8'h20 : 8'h00, 1'b1);
			@(posedge ref_clk_i);
			core.xoff_seen <= 1'b1;
			@(posedge ref_clk_i);
			core.xoff_seen <= 1'b0;
			note(x == 0 ? SRC_XOFF : SRC_NONE, x == 0);
			uie_host_model_inst.strobe(1'b1, 1'b0);
		end
		wrap_up();
	end
endmodule // uie_top_tb
`default_nettype wire
